// ==== mux_decode_pkg.sv ====
// constants, types and decode function for the multiplexed-bus strobe decoder
package mux_decode_pkg;

	localparam int          ADDR_W        = 16;
	localparam int          DATA_W        = 8;
	localparam int          PORT_N        = 8;
	localparam int          SYNC_STAGES   = 2;
	localparam logic [15:0] RD_BASE_RST   = 16'h1000;
	localparam logic [15:0] WR_BASE_RST   = 16'h1800;
	localparam logic [7:0]  STROBE_IDLE   = 8'hFF;
	localparam logic [7:0]  DATA_RST      = 8'h00;
	localparam logic [15:0] ADDR_RST      = 16'h0000;

	typedef logic [PORT_N-1:0] strobe_t;

	// active-low one-of-eight select when addr lies in base..base+7
	function automatic strobe_t strobe_decode
	(
		input logic [15:0] addr,
		input logic [15:0] base,
		input logic        en
	);
		strobe_t     res;
		logic [15:0] off;
		res = STROBE_IDLE;
		off = addr - base;
		if (en && (addr >= base) && (off < 16'h0008))
		begin
			res[off[2:0]] = 1'b0;
		end
		return res;
	endfunction

endpackage

// ==== port_strobe_if.sv ====
// carrier between the decoder and the output register bank
`timescale 1ns/10ps
interface port_strobe_if;
	import mux_decode_pkg::*;

	logic [7:0]                load_n;
	logic [7:0]                load_data;
	logic [PORT_N-1:0][7:0]    port_q;

	modport decoder (output load_n, output load_data, input port_q);
	modport bank    (input load_n, input load_data, output port_q);
endinterface

// ==== port_bank.sv ====
// eight output registers loaded on the rising edge of their write strobe
`timescale 1ns/10ps
module port_bank
	import mux_decode_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       ce_i,
	port_strobe_if.bank     st
);

	logic [7:0]             load_n_d_r;
	logic [PORT_N-1:0][7:0] port_r;

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			load_n_d_r <= STROBE_IDLE;
		else if (ce_i)
			load_n_d_r <= st.load_n;
	end

	// load on low-to-high transition of each strobe
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			for (int i = 0; i < PORT_N; i++)
				port_r[i] <= DATA_RST;
		end
		else if (ce_i)
		begin
			for (int i = 0; i < PORT_N; i++)
				if (st.load_n[i] && !load_n_d_r[i])
					port_r[i] <= st.load_data;
		end
	end

	assign st.port_q = port_r;

	a_load_on_rise: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && st.load_n[0] && !load_n_d_r[0]) |=> (port_r[0] == $past(st.load_data)))
		else $error("output port 0 not loaded on strobe rise");

	a_hold_no_edge: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && !(st.load_n[3] && !load_n_d_r[3])) |=> $stable(port_r[3]))
		else $error("output port 3 changed without a strobe rise");

endmodule

// ==== mux_bus_addr_decode_strobes.sv ====
// demultiplexes the processor bus and decodes read and write port strobes
`timescale 1ns/10ps
module mux_bus_addr_decode_strobes
	import mux_decode_pkg::*;
#(
	parameter logic [15:0] RD_BASE = RD_BASE_RST,
	parameter logic [15:0] WR_BASE = WR_BASE_RST
)
(
	input  wire logic                   clk_i,
	input  wire logic                   rst_n_i,
	input  wire logic                   ce_i,
	input  wire logic                   addr_phase_strobe_i,
	input  wire logic                   rw_i,
	input  wire logic [7:0]             addr_hi_i,
	input  wire logic [7:0]             ad_i,
	output logic      [7:0]             ad_o,
	output logic                        ad_oe_o,
	output logic      [15:0]            addr_o,
	output logic      [7:0]             input_port_select_n_o,
	output logic      [7:0]             output_port_load_n_o,
	input  wire logic [PORT_N-1:0][7:0] in_port_i,
	output logic      [PORT_N-1:0][7:0] out_port_o
);

	logic                   as_s1_r;
	logic                   as_s2_r;
	logic                   as_d_r;
	logic                   rw_s1_r;
	logic                   rw_s2_r;
	logic [7:0]             ad_s1_r;
	logic [7:0]             ad_s2_r;
	logic [7:0]             hi_s1_r;
	logic [7:0]             hi_s2_r;
	logic [PORT_N-1:0][7:0] in_s1_r;
	logic [PORT_N-1:0][7:0] in_s2_r;
	logic [7:0]             addr_lo_r;
	logic [7:0]             addr_hi_r;
	logic                   cycle_open_r;
	logic [7:0]             data_hold_r;
	logic [7:0]             rd_n_r;
	logic [7:0]             wr_n_r;
	logic [7:0]             ad_r;
	logic                   ad_oe_r;
	logic [15:0]            addr_r;
	logic [15:0]            addr_nxt;
	logic                   data_phase;
	strobe_t                rd_n_nxt;
	strobe_t                wr_n_nxt;
	logic [7:0]             rd_data_nxt;

	port_strobe_if st ();

	// two-stage synchronisers on all pins from the processor and the board
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			as_s1_r <= 1'b0;
			as_s2_r <= 1'b0;
			rw_s1_r <= 1'b1;
			rw_s2_r <= 1'b1;
			ad_s1_r <= DATA_RST;
			ad_s2_r <= DATA_RST;
			hi_s1_r <= DATA_RST;
			hi_s2_r <= DATA_RST;
			in_s1_r <= '0;
			in_s2_r <= '0;
		end
		else if (ce_i)
		begin
			as_s1_r <= addr_phase_strobe_i;
			as_s2_r <= as_s1_r;
			rw_s1_r <= rw_i;
			rw_s2_r <= rw_s1_r;
			ad_s1_r <= ad_i;
			ad_s2_r <= ad_s1_r;
			hi_s1_r <= addr_hi_i;
			hi_s2_r <= hi_s1_r;
			in_s1_r <= in_port_i;
			in_s2_r <= in_s1_r;
		end
	end

	// address latch: transparent while the strobe is high, holds after it falls
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			addr_lo_r <= DATA_RST;
			addr_hi_r <= DATA_RST;
			as_d_r    <= 1'b0;
		end
		else if (ce_i)
		begin
			as_d_r <= as_s2_r;
			if (as_s2_r)
			begin
				addr_lo_r <= ad_s2_r;
				addr_hi_r <= hi_s2_r;
			end
		end
	end

	// no strobes until a first address phase has been seen
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			cycle_open_r <= 1'b0;
		else if (ce_i && as_s2_r)
			cycle_open_r <= 1'b1;
	end

	// write data captured during the data phase; bus turns to address when strobe rises
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			data_hold_r <= DATA_RST;
		else if (ce_i && data_phase)
			data_hold_r <= ad_s2_r;
	end

	always_comb
	begin
		addr_nxt    = {addr_hi_r, addr_lo_r};
		data_phase  = cycle_open_r && !as_s2_r;
		rd_n_nxt    = strobe_decode(addr_nxt, RD_BASE, data_phase && rw_s2_r);
		wr_n_nxt    = strobe_decode(addr_nxt, WR_BASE, data_phase && !rw_s2_r);
		rd_data_nxt = DATA_RST;
		for (int i = 0; i < PORT_N; i++)
			if (!rd_n_nxt[i])
				rd_data_nxt = in_s2_r[i];
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			rd_n_r <= STROBE_IDLE;
			wr_n_r <= STROBE_IDLE;
			addr_r <= ADDR_RST;
		end
		else if (ce_i)
		begin
			rd_n_r <= rd_n_nxt;
			wr_n_r <= wr_n_nxt;
			addr_r <= addr_nxt;
		end
	end

	// selected input buffer drives the bus while its strobe is low
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			ad_r    <= DATA_RST;
			ad_oe_r <= 1'b0;
		end
		else if (ce_i)
		begin
			ad_r    <= rd_data_nxt;
			ad_oe_r <= (rd_n_nxt != STROBE_IDLE);
		end
	end

	assign st.load_n    = wr_n_r;
	assign st.load_data = data_hold_r;

	port_bank u_bank
	(
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.ce_i    (ce_i),
		.st      (st.bank)
	);

	assign ad_o                  = ad_r;
	assign ad_oe_o               = ad_oe_r;
	assign addr_o                = addr_r;
	assign input_port_select_n_o = rd_n_r;
	assign output_port_load_n_o  = wr_n_r;
	assign out_port_o            = st.port_q;

	a_one_strobe_max: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$countones(~{rd_n_r, wr_n_r}) <= 1)
		else $error("more than one port strobe asserted");

	a_no_strobe_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && as_s2_r) |=> (rd_n_r == STROBE_IDLE && wr_n_r == STROBE_IDLE))
		else $error("strobe asserted during address phase");

	a_addr_latch_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && !as_s2_r) |=> $stable(addr_lo_r))
		else $error("low address changed while strobe low");

	a_addr_latch_cap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && as_s2_r) |=> (addr_lo_r == $past(ad_s2_r)))
		else $error("low address not captured while strobe high");

	a_read_decode: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && data_phase && rw_s2_r && addr_nxt == RD_BASE) |=> !rd_n_r[0])
		else $error("read strobe 0 not decoded");

	a_write_decode: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && data_phase && !rw_s2_r && addr_nxt == WR_BASE + 16'h0007)
		|=> !wr_n_r[7] && rd_n_r == STROBE_IDLE)
		else $error("write strobe 7 not decoded");

	a_read_no_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && !rw_s2_r) |=> (rd_n_r == STROBE_IDLE))
		else $error("read strobe without read direction");

	a_bus_drive: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(rd_n_r != STROBE_IDLE) == ad_oe_r)
		else $error("bus drive does not match read strobe");

	a_read_data: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && !rd_n_nxt[2]) |=> (ad_r == $past(in_s2_r[2])))
		else $error("read data not from selected input port");

	a_addr_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i |=> (addr_o == $past({addr_hi_r, addr_lo_r})))
		else $error("address output does not follow latch");

	c_read_cycle:  cover property (@(posedge clk_i) disable iff (!rst_n_i)
		$fell(as_s2_r) ##[1:4] ad_oe_r);
	c_write_cycle: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		!wr_n_r[1] ##1 wr_n_r[1]);
	c_back_to_back: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		!wr_n_r[7] ##[1:40] !rd_n_r[0]);
	c_ce_freeze:   cover property (@(posedge clk_i) disable iff (!rst_n_i)
		!ce_i && !rd_n_r[4]);

endmodule

// ==== cpu_bus_model.sv ====
// processor side of the multiplexed address/data bus
`timescale 1ns/10ps
module cpu_bus_model
(
	input  wire logic       clk_i,
	output logic            addr_strobe_o,
	output logic            rw_o,
	output logic [7:0]      addr_hi_o,
	output logic [7:0]      bus_o
);
	initial
	begin
		addr_strobe_o = 1'b1;
		rw_o = 1'b1;
		addr_hi_o = 8'h00;
		bus_o = 8'h00;
	end

	// address phase, then data phase; a read releases the bus (inverted last value)
	task automatic open_cycle(input logic rw, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_strobe_o <= 1'b1;
		rw_o <= rw;
		addr_hi_o <= a[15:8];
		bus_o <= a[7:0];
		repeat (4) @(posedge clk_i);
		addr_strobe_o <= 1'b0;
		bus_o <= rw ? ~a[7:0] : d;
		repeat (6) @(posedge clk_i);
	endtask

	// ends the data phase with an idle address phase
	task automatic close_cycle();
		@(posedge clk_i);
		addr_strobe_o <= 1'b1;
		bus_o <= 8'hFF;
		repeat (5) @(posedge clk_i);
	endtask
endmodule

// ==== mux_bus_addr_decode_strobes_bench.sv ====
// self-checking bench for the bus demultiplexer and port strobe decoder
`timescale 1ns/10ps
module mux_bus_addr_decode_strobes_bench;
	import mux_decode_pkg::*;

	logic                   clk_i;
	logic                   rst_n_i;
	logic                   ce_i;
	logic                   cpu_strobe;
	logic                   rw;
	logic [7:0]             addr_hi;
	logic [7:0]             cpu_bus;
	logic [7:0]             ad_o;
	logic                   ad_oe_o;
	logic [7:0]             ad_wire;
	logic [15:0]            addr_o;
	logic [7:0]             rd_n;
	logic [7:0]             wr_n;
	logic [PORT_N-1:0][7:0] in_port_i;
	logic [PORT_N-1:0][7:0] out_port_o;
	logic [7:0]             exp_out [PORT_N];
	logic [7:0]             seed;
	logic [7:0]             hit;
	int                     failures;
	int                     comparisons;

	assign ad_wire = ad_oe_o ? ad_o : cpu_bus;

	cpu_bus_model u_cpu
	(
		.clk_i         (clk_i),
		.addr_strobe_o (cpu_strobe),
		.rw_o          (rw),
		.addr_hi_o     (addr_hi),
		.bus_o         (cpu_bus)
	);

	mux_bus_addr_decode_strobes u_dut
	(
		.clk_i                 (clk_i),
		.rst_n_i               (rst_n_i),
		.ce_i                  (ce_i),
		.addr_phase_strobe_i   (cpu_strobe),
		.rw_i                  (rw),
		.addr_hi_i             (addr_hi),
		.ad_i                  (ad_wire),
		.ad_o                  (ad_o),
		.ad_oe_o               (ad_oe_o),
		.addr_o                (addr_o),
		.input_port_select_n_o (rd_n),
		.output_port_load_n_o  (wr_n),
		.in_port_i             (in_port_i),
		.out_port_o            (out_port_o)
	);

	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic chk_val(input string what, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			failures++;
			$display("FAIL %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic chk_addr(input string what, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e)
		begin
			failures++;
			$display("FAIL %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic chk_outs();
		for (int k = 0; k < PORT_N; k++)
		begin
			chk_val("out port", exp_out[k], out_port_o[k]);
		end
	endtask

	task automatic report_and_stop();
		$display("failures=%0d comparisons=%0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	initial
	begin
		repeat (5000) @(posedge clk_i);
		failures++;
		report_and_stop();
	end

	initial
	begin
		logic [15:0] a;
		logic [7:0]  held;
		failures = 0;
		comparisons = 0;
		rst_n_i = 1'b0;
		ce_i = 1'b1;
		in_port_i = '0;
		seed = 8'h5F;
		for (int k = 0; k < PORT_N; k++)
			exp_out[k] = 8'h00;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		#1;
		chk_val("rd idle", 8'hFF, rd_n);
		chk_outs();
		// writes first, then reads; offset 8 lies outside each window
		for (int r = 0; r < 2; r++)
		begin
			for (int n = 0; n < 9; n++)
			begin
				@(posedge clk_i);
				for (int k = 0; k < PORT_N; k++)
				begin
					seed = lfsr_next(seed);
					in_port_i[k] <= seed;
				end
				seed = lfsr_next(seed);
				a = (r == 1) ? 16'(RD_BASE_RST + n) : 16'(WR_BASE_RST + n);
				hit = (n < 8) ? ~(8'h01 << n) : 8'hFF;
				u_cpu.open_cycle(r[0], a, seed);
				#1;
				chk_addr("address", a, addr_o);
				chk_val("rd strobes", r ? hit : 8'hFF, rd_n);
				chk_val("wr strobes", r ? 8'hFF : hit, wr_n);
				chk_val("bus drive", {7'h00, r == 1 && n < 8}, {7'h00, ad_oe_o});
				if (r == 1 && n < 8)
					chk_val("read data", in_port_i[n], ad_wire);
				if (r == 0 && n < 8)
					exp_out[n] = seed;
				u_cpu.close_cycle();
				#1;
				chk_val("strobes off", 8'hFF, rd_n & wr_n);
				chk_outs();
			end
		end
		// clock enable low in a read data phase freezes strobe and bus data
		seed = lfsr_next(seed);
		a = 16'(RD_BASE_RST + 4);
		u_cpu.open_cycle(1'b1, a, seed);
		#1;
		chk_val("rd strobes", 8'hEF, rd_n);
		chk_val("read data", in_port_i[4], ad_wire);
		held = in_port_i[4];
		@(posedge clk_i);
		ce_i <= 1'b0;
		in_port_i[4] <= seed;
		repeat (3) @(posedge clk_i);
		#1;
		chk_val("frozen rd strobes", 8'hEF, rd_n);
		chk_val("frozen read data", held, ad_wire);
		@(posedge clk_i);
		ce_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		#1;
		chk_val("thawed read data", seed, ad_wire);
		u_cpu.close_cycle();
		#1;
		chk_val("strobes off", 8'hFF, rd_n & wr_n);
		// reset in a write data phase: no load, no strobe until a new address phase
		seed = lfsr_next(seed);
		a = 16'(WR_BASE_RST + 2);
		u_cpu.open_cycle(1'b0, a, seed);
		#1;
		chk_val("wr strobes", 8'hFB, wr_n);
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		for (int k = 0; k < PORT_N; k++)
			exp_out[k] = 8'h00;
		repeat (3) @(posedge clk_i);
		#1;
		chk_val("wr after reset", 8'hFF, wr_n);
		chk_val("bus drive after reset", 8'h00, {7'h00, ad_oe_o});
		chk_addr("address after reset", ADDR_RST, addr_o);
		chk_outs();
		u_cpu.close_cycle();
		#1;
		chk_val("strobes off", 8'hFF, rd_n & wr_n);
		chk_outs();
		// first write after the mid-run reset
		seed = lfsr_next(seed);
		a = 16'(WR_BASE_RST + 5);
		u_cpu.open_cycle(1'b0, a, seed);
		#1;
		chk_addr("address", a, addr_o);
		chk_val("wr strobes", 8'hDF, wr_n);
		exp_out[5] = seed;
		u_cpu.close_cycle();
		#1;
		chk_outs();
		report_and_stop();
	end
endmodule
